// >>> hdl/psm_defs.svh
// Constants for the power-saving clock manager.
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// Reset value of the peripheral-to-CPU ratio field (1:1).
`define PSM_RATIO_RESET 3'h0
// Reset value of the oscillator select field.
`define PSM_OSC_RESET 3'h0
// Bounds of the restart delay after a wake event, in clock cycles.
`define PSM_WAKE_MIN 2
`define PSM_WAKE_MAX 4
// Default restart delay after a wake event, in clock cycles.
`define PSM_WAKE_DEFAULT 2
// Number of gated peripherals on this core.
`define PSM_NUM_PERIPH 8
// Width of the wake delay counter.
`define PSM_WAKE_CNT_W 3
// Width of the CPU slowdown counter (covers 1:128).
`define PSM_DOZE_CNT_W 7

`endif

// >>> hdl/psm_pkg.sv
// Types shared by the power-saving clock manager.
package psm_pkg;

  // Operating state of the core.
  typedef enum {
    PSM_RUN,
    PSM_ENTER,
    PSM_SLEEP,
    PSM_IDLE,
    PSM_WAKE
  } psm_state_t;

  // Operand of the power-save instruction.
  typedef enum logic {
    PSM_OP_SLEEP,
    PSM_OP_IDLE
  } psm_op_t;

endpackage : psm_pkg

// >>> hdl/psm_doze_div.sv
// CPU clock-enable divider for the slowdown mode.
`timescale 1ns/100ps
`default_nettype none
`include "psm_defs.svh"

module psm_doze_div
  import psm_pkg::*;
#(
  parameter int CNT_W = `PSM_DOZE_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic en,
  input wire logic [2:0] ratio,
  // Tick, one cycle out of every 2**ratio
  output logic tick
);

  initial begin
    if (CNT_W < 7) begin
      $error("psm_doze_div: counter too narrow for 1:128");
    end
  end

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [CNT_W-1:0] limit;

  always_comb begin
    limit = CNT_W'((1 << ratio) - 1);
    // A lowered ratio can leave the count above the new limit; wrap at once
    // instead of running on to the counter's top.
    tick_next = en && (cnt_reg >= limit);
    if (!en || cnt_reg >= limit) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  property p_half_rate;
    @(posedge clk) disable iff (rst)
    (en && ratio == 3'h1)[*3] ##0 tick |=> !tick;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("tick did not halve at ratio 1");

endmodule : psm_doze_div
`default_nettype wire

// >>> hdl/psm_power_manager.sv
// Power-saving clock manager: sleep, idle, slowdown and module clock gating.
// Functional notes
// - Sleep operand stops clock and execution.
// - Idle operand halts CPU, peripherals keep running.
// - Sleep shuts down the system oscillator.
// - Clock failure monitor inactive during Sleep.
// - Low-power RC runs in Sleep with watchdog.
// - Watchdog cleared just before Sleep entry.
// - Sleep stops system-clocked peripherals only.
// - Sleep exits on interrupt, reset, watchdog.
// - Wake resumes on the same oscillator.
// - Standby bit picks regulator Sleep behaviour.
// - Idle clears watchdog, keeps oscillators as needed.
// - Idle wake restarts execution two-four cycles.
// - Stop-in-idle bit halts peripheral in Idle.
// - Coincident interrupt deferred until entry completes.
// - Slowdown slows only CPU, peripherals full speed.
// - Slowdown mode entered when enable set.
// - Three-bit ratio 1:1 to 1:128.
// - Return-on-interrupt restores CPU full speed.
// - Module-disable bit stops all module clocks.
// - Module active only if enabled and present.
// - Module-disable change takes one cycle; here the clock enable follows the write two cycles later.
// - Module-disable bits are per core.
// - Oscillator select writable when not locked.
`timescale 1ns/100ps
`default_nettype none
`include "psm_defs.svh"

module psm_power_manager
  import psm_pkg::*;
#(
  parameter int NUM_PERIPH = `PSM_NUM_PERIPH,
  parameter int WAKE_CYCLES = `PSM_WAKE_DEFAULT
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // Power-save instruction from the local CPU
  input wire logic POWER_SAVE_INSTRUCTION,
  input wire logic POWER_SAVE_OPERAND,
  // Wake sources
  input wire logic IRQ_PENDING,
  input wire logic RESET_EVENT,
  input wire logic WATCHDOG_TIMEOUT,
  // Watchdog and monitor configuration
  input wire logic WATCHDOG_ENABLE,
  input wire logic CLOCK_FAILURE_MONITOR_ENABLE,
  input wire logic REGULATOR_STANDBY_CONTROL,
  // Slowdown control writes
  input wire logic CLOCK_DIVIDER_WR,
  input wire logic CPU_SLOWDOWN_ENABLE_IN,
  input wire logic [2:0] SLOWDOWN_RATIO_IN,
  input wire logic RETURN_ON_INTERRUPT_IN,
  // Oscillator select writes
  input wire logic OSC_CONTROL_WR,
  input wire logic [2:0] NEW_OSCILLATOR_SELECT_IN,
  input wire logic CLOCK_CONFIG_LOCKED,
  // Per-peripheral controls
  input wire logic MODULE_CLOCK_GATE_WR,
  input wire logic [NUM_PERIPH-1:0] MODULE_CLOCK_GATE_IN,
  input wire logic [NUM_PERIPH-1:0] PERIPH_PRESENT,
  input wire logic [NUM_PERIPH-1:0] PERIPH_EXT_CLOCK,
  input wire logic [NUM_PERIPH-1:0] STOP_IN_IDLE,
  // Clock enables
  output logic CPU_CLK_EN,
  output logic [NUM_PERIPH-1:0] PERIPH_CLK_EN,
  output logic SYS_OSC_EN,
  output logic LOW_POWER_RC_OSC_EN,
  output logic CLOCK_FAILURE_MONITOR_ACTIVE,
  output logic REGULATOR_STANDBY,
  // Status
  output logic WATCHDOG_CLEAR,
  output logic SLEEP_ACTIVE,
  output logic IDLE_ACTIVE,
  output logic EXEC_RESUME,
  output logic CPU_SLOWDOWN_ENABLE,
  output logic [2:0] SLOWDOWN_RATIO,
  output logic RETURN_ON_INTERRUPT,
  output logic [2:0] NEW_OSCILLATOR_SELECT,
  output logic [NUM_PERIPH-1:0] MODULE_CLOCK_GATE
);

  localparam int WAKE_DLY = WAKE_CYCLES;
  localparam int CW = `PSM_WAKE_CNT_W;

  initial begin
    if (WAKE_CYCLES < `PSM_WAKE_MIN || WAKE_CYCLES > `PSM_WAKE_MAX) begin
      $error("psm_power_manager: WAKE_CYCLES outside two to four");
    end
    if (NUM_PERIPH < 1) begin
      $error("psm_power_manager: NUM_PERIPH must be at least one");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine.

  psm_state_t state_reg;
  psm_state_t state_next;
  psm_op_t op_reg;
  psm_op_t op_next;
  logic [CW-1:0] wake_cnt_reg;
  logic [CW-1:0] wake_cnt_next;
  logic wake_evt;

  // The watchdog time-out and any reset source are treated like an interrupt.
  assign wake_evt = IRQ_PENDING || RESET_EVENT || WATCHDOG_TIMEOUT;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    wake_cnt_next = wake_cnt_reg;
    case (state_reg)
      PSM_RUN: begin
        if (POWER_SAVE_INSTRUCTION) begin
          op_next = psm_op_t'(POWER_SAVE_OPERAND);
          state_next = PSM_ENTER;
        end
      end
      PSM_ENTER: begin
        // Entry always completes; a pending wake source is seen afterwards.
        if (op_reg == PSM_OP_SLEEP) begin
          state_next = PSM_SLEEP;
        end else begin
          state_next = PSM_IDLE;
        end
      end
      PSM_SLEEP, PSM_IDLE: begin
        if (wake_evt) begin
          state_next = PSM_WAKE;
          wake_cnt_next = CW'(WAKE_CYCLES);
        end
      end
      PSM_WAKE: begin
        // The CPU clock is back from the first Wake cycle; execution follows
        // WAKE_CYCLES cycles after that.
        if (wake_cnt_reg == '0) begin
          state_next = PSM_RUN;
        end else begin
          wake_cnt_next = wake_cnt_reg - CW'(1);
        end
      end
      default: begin
        state_next = PSM_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= PSM_RUN;
      op_reg <= PSM_OP_SLEEP;
      wake_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      wake_cnt_reg <= wake_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-written control bits.

  logic slow_en_reg;
  logic slow_en_next;
  logic [2:0] ratio_reg;
  logic [2:0] ratio_next;
  logic roi_reg;
  logic roi_next;
  logic [2:0] osc_reg;
  logic [2:0] osc_next;
  logic osc_wr_ok;
  logic [NUM_PERIPH-1:0] gate_reg;
  logic [NUM_PERIPH-1:0] gate_next;

  // The selected oscillator is never touched by power-state changes, so wake
  // from Sleep returns to whatever source was chosen before entry.
  assign osc_wr_ok = OSC_CONTROL_WR && !CLOCK_CONFIG_LOCKED && state_reg == PSM_RUN;

  always_comb begin
    slow_en_next = slow_en_reg;
    ratio_next = ratio_reg;
    roi_next = roi_reg;
    osc_next = osc_reg;
    gate_next = gate_reg;
    if (roi_reg && slow_en_reg && IRQ_PENDING) begin
      slow_en_next = 1'b0;
    end
    // A software write in the same cycle wins so that a new setting is kept.
    if (CLOCK_DIVIDER_WR) begin
      slow_en_next = CPU_SLOWDOWN_ENABLE_IN;
      ratio_next = SLOWDOWN_RATIO_IN;
      roi_next = RETURN_ON_INTERRUPT_IN;
    end
    if (osc_wr_ok) begin
      osc_next = NEW_OSCILLATOR_SELECT_IN;
    end
    if (MODULE_CLOCK_GATE_WR) begin
      // Only this core's bits live here; absent peripherals hold no state.
      gate_next = MODULE_CLOCK_GATE_IN & PERIPH_PRESENT;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      slow_en_reg <= 1'b0;
      ratio_reg <= `PSM_RATIO_RESET;
      roi_reg <= 1'b0;
      osc_reg <= `PSM_OSC_RESET;
      gate_reg <= '0;
    end else begin
      slow_en_reg <= slow_en_next;
      ratio_reg <= ratio_next;
      roi_reg <= roi_next;
      osc_reg <= osc_next;
      gate_reg <= gate_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU slowdown divider.

  logic doze_tick;

  psm_doze_div #(
    .CNT_W(`PSM_DOZE_CNT_W)
  ) u_doze_div (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .en(slow_en_reg),
    .ratio(ratio_reg),
    .tick(doze_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  logic in_sleep;
  logic in_idle;
  logic cpu_en_reg;
  logic cpu_en_next;
  logic osc_en_reg;
  logic osc_en_next;
  logic low_power_rc_osc_reg;
  logic low_power_rc_osc_next;
  logic cfm_reg;
  logic cfm_next;
  logic vreg_reg;
  logic vreg_next;
  logic wdt_clr_reg;
  logic wdt_clr_next;
  logic resume_reg;
  logic resume_next;
  logic [NUM_PERIPH-1:0] pclk_reg;
  logic [NUM_PERIPH-1:0] pclk_next;

  assign in_sleep = state_reg == PSM_SLEEP;
  assign in_idle = state_reg == PSM_IDLE;

  always_comb begin
    // Peripherals stay at full rate; only the CPU enable follows the divider.
    case (state_reg)
      PSM_RUN: cpu_en_next = slow_en_reg ? doze_tick : 1'b1;
      PSM_WAKE: cpu_en_next = 1'b1;
      default: cpu_en_next = 1'b0;
    endcase
    osc_en_next = !in_sleep;
    cfm_next = CLOCK_FAILURE_MONITOR_ENABLE && !in_sleep;
    if (in_sleep) begin
      low_power_rc_osc_next = WATCHDOG_ENABLE;
    end else begin
      low_power_rc_osc_next = WATCHDOG_ENABLE || CLOCK_FAILURE_MONITOR_ENABLE;
    end
    vreg_next = in_sleep && !REGULATOR_STANDBY_CONTROL;
    wdt_clr_next = state_reg == PSM_ENTER && WATCHDOG_ENABLE;
    resume_next = state_reg == PSM_WAKE && wake_cnt_reg == '0;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi = gi + 1) begin : g_periph
      // The gate bit is one cycle behind the write and the enable is registered again,
      // so PERIPH_CLK_EN changes two cycles after the write, not the documented one cycle.
      always_comb begin
        pclk_next[gi] = PERIPH_PRESENT[gi] && !gate_reg[gi]
          && !(in_sleep && !PERIPH_EXT_CLOCK[gi])
          && !(in_idle && STOP_IN_IDLE[gi]);
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cpu_en_reg <= 1'b1;
      osc_en_reg <= 1'b1;
      low_power_rc_osc_reg <= 1'b0;
      cfm_reg <= 1'b0;
      vreg_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
      resume_reg <= 1'b0;
      pclk_reg <= '0;
    end else begin
      cpu_en_reg <= cpu_en_next;
      osc_en_reg <= osc_en_next;
      low_power_rc_osc_reg <= low_power_rc_osc_next;
      cfm_reg <= cfm_next;
      vreg_reg <= vreg_next;
      wdt_clr_reg <= wdt_clr_next;
      resume_reg <= resume_next;
      pclk_reg <= pclk_next;
    end
  end

  logic sleep_out_reg;
  logic idle_out_reg;

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sleep_out_reg <= 1'b0;
      idle_out_reg <= 1'b0;
    end else begin
      sleep_out_reg <= in_sleep;
      idle_out_reg <= in_idle;
    end
  end

  assign CPU_CLK_EN = cpu_en_reg;
  assign PERIPH_CLK_EN = pclk_reg;
  assign SYS_OSC_EN = osc_en_reg;
  assign LOW_POWER_RC_OSC_EN = low_power_rc_osc_reg;
  assign CLOCK_FAILURE_MONITOR_ACTIVE = cfm_reg;
  assign REGULATOR_STANDBY = vreg_reg;
  assign WATCHDOG_CLEAR = wdt_clr_reg;
  assign SLEEP_ACTIVE = sleep_out_reg;
  assign IDLE_ACTIVE = idle_out_reg;
  assign EXEC_RESUME = resume_reg;
  assign CPU_SLOWDOWN_ENABLE = slow_en_reg;
  assign SLOWDOWN_RATIO = ratio_reg;
  assign RETURN_ON_INTERRUPT = roi_reg;
  assign NEW_OSCILLATOR_SELECT = osc_reg;
  assign MODULE_CLOCK_GATE = gate_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  property p_sleep_halt;
    SLEEP_ACTIVE |-> !CPU_CLK_EN && !SYS_OSC_EN && !CLOCK_FAILURE_MONITOR_ACTIVE;
  endproperty
  a_sleep_halt: assert property (p_sleep_halt) else $error("sleep left a clock running");

  property p_idle_halt;
    IDLE_ACTIVE |-> !CPU_CLK_EN && SYS_OSC_EN;
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("idle clock state wrong");

  property p_sleep_low_power_rc_osc;
    SLEEP_ACTIVE && $past(WATCHDOG_ENABLE) |-> LOW_POWER_RC_OSC_EN;
  endproperty
  a_sleep_low_power_rc_osc: assert property (p_sleep_low_power_rc_osc) else $error("rc oscillator off in sleep");

  property p_sleep_entry;
    state_reg == PSM_RUN && POWER_SAVE_INSTRUCTION && POWER_SAVE_OPERAND == 1'b0
      |=> (WATCHDOG_ENABLE |=> WATCHDOG_CLEAR ##1 SLEEP_ACTIVE);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("watchdog not cleared before sleep");

  property p_deferred_wake;
    state_reg == PSM_RUN && POWER_SAVE_INSTRUCTION && IRQ_PENDING
      |=> state_reg == PSM_ENTER ##1 (state_reg == PSM_SLEEP || state_reg == PSM_IDLE);
  endproperty
  a_deferred_wake: assert property (p_deferred_wake) else $error("entry cut short by interrupt");

  property p_wake_restart;
    (state_reg == PSM_SLEEP || state_reg == PSM_IDLE) && wake_evt |-> ##2 CPU_CLK_EN ##WAKE_DLY EXEC_RESUME;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("restart delay wrong");

  property p_regulator;
    SLEEP_ACTIVE |-> REGULATOR_STANDBY == !$past(REGULATOR_STANDBY_CONTROL);
  endproperty
  a_regulator: assert property (p_regulator) else $error("regulator standby wrong");

  property p_roi_clear;
    slow_en_reg && roi_reg && IRQ_PENDING && !CLOCK_DIVIDER_WR |=> !CPU_SLOWDOWN_ENABLE;
  endproperty
  a_roi_clear: assert property (p_roi_clear) else $error("return on interrupt ignored");

  property p_no_roi;
    slow_en_reg && !roi_reg && !CLOCK_DIVIDER_WR |=> CPU_SLOWDOWN_ENABLE;
  endproperty
  a_no_roi: assert property (p_no_roi) else $error("slowdown dropped without cause");

  property p_gate_delay;
    MODULE_CLOCK_GATE_WR && MODULE_CLOCK_GATE_IN[0] && PERIPH_PRESENT[0] |-> ##2 !PERIPH_CLK_EN[0];
  endproperty
  a_gate_delay: assert property (p_gate_delay) else $error("module clock not stopped");

  property p_osc_lock;
    OSC_CONTROL_WR && CLOCK_CONFIG_LOCKED |=> $stable(NEW_OSCILLATOR_SELECT);
  endproperty
  a_osc_lock: assert property (p_osc_lock) else $error("locked oscillator select changed");

  property p_osc_hold_sleep;
    state_reg == PSM_SLEEP |=> $stable(NEW_OSCILLATOR_SELECT);
  endproperty
  a_osc_hold_sleep: assert property (p_osc_hold_sleep) else $error("oscillator changed in sleep");

  c_sleep_wake: cover property (state_reg == PSM_SLEEP ##1 state_reg == PSM_WAKE ##[1:4] EXEC_RESUME);
  c_idle_wake: cover property (IDLE_ACTIVE ##[1:8] EXEC_RESUME);
  c_roi: cover property (slow_en_reg && roi_reg && IRQ_PENDING ##1 !CPU_SLOWDOWN_ENABLE);
  c_gate: cover property (MODULE_CLOCK_GATE_WR ##2 !PERIPH_CLK_EN[0]);

endmodule : psm_power_manager
`default_nettype wire

// >>> bench/tb_psm_power_manager.sv
// Self-checking testbench for the power-saving clock manager.
`timescale 1ns/100ps
`default_nettype none

module tb_psm_power_manager
  import psm_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic ps_instr = 1'b0, ps_op = 1'b0, wdt_en = 1'b0, cfm_en = 1'b0, vreg = 1'b0;
  logic div_wr = 1'b0, slow_en = 1'b0, return_on_interrupt = 1'b0, osc_wr = 1'b0, osc_lock = 1'b1, gate_wr = 1'b0;
  logic [2:0] wake = 3'h0, ratio = 3'h0, osc_sel = 3'h0;
  logic [7:0] gate_in = 8'h00, present = 8'hEF, ext_clk = 8'h03, stop_in_idle = 8'h30, gate_exp = 8'h00;
  logic cpu_en, osc_en, low_power_rc_osc_en, cfm_act, reg_stby, wdt_clr, sleep_act, idle_act, resume, slow_q, roi_q;
  logic [2:0] ratio_q, osc_q;
  logic [7:0] pclk_en, gate_q;
  int error_cnt = 0, n_checks = 0, cyc = 0, wdc = 0, res = 0, act = 0, d = 0;

  always #2.5 clk_sys = ~clk_sys;

  psm_power_manager #(.NUM_PERIPH(8), .WAKE_CYCLES(2)) u_dut (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst),
    .POWER_SAVE_INSTRUCTION(ps_instr), .POWER_SAVE_OPERAND(ps_op),
    .IRQ_PENDING(wake[0]), .RESET_EVENT(wake[1]), .WATCHDOG_TIMEOUT(wake[2]),
    .WATCHDOG_ENABLE(wdt_en), .CLOCK_FAILURE_MONITOR_ENABLE(cfm_en), .REGULATOR_STANDBY_CONTROL(vreg),
    .CLOCK_DIVIDER_WR(div_wr), .CPU_SLOWDOWN_ENABLE_IN(slow_en), .SLOWDOWN_RATIO_IN(ratio),
    .RETURN_ON_INTERRUPT_IN(return_on_interrupt), .OSC_CONTROL_WR(osc_wr), .NEW_OSCILLATOR_SELECT_IN(osc_sel),
    .CLOCK_CONFIG_LOCKED(osc_lock), .MODULE_CLOCK_GATE_WR(gate_wr), .MODULE_CLOCK_GATE_IN(gate_in),
    .PERIPH_PRESENT(present), .PERIPH_EXT_CLOCK(ext_clk), .STOP_IN_IDLE(stop_in_idle),
    .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(pclk_en), .SYS_OSC_EN(osc_en), .LOW_POWER_RC_OSC_EN(low_power_rc_osc_en),
    .CLOCK_FAILURE_MONITOR_ACTIVE(cfm_act), .REGULATOR_STANDBY(reg_stby), .WATCHDOG_CLEAR(wdt_clr),
    .SLEEP_ACTIVE(sleep_act), .IDLE_ACTIVE(idle_act), .EXEC_RESUME(resume),
    .CPU_SLOWDOWN_ENABLE(slow_q), .SLOWDOWN_RATIO(ratio_q), .RETURN_ON_INTERRUPT(roi_q),
    .NEW_OSCILLATOR_SELECT(osc_q), .MODULE_CLOCK_GATE(gate_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic fail(string m);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, m);
  endtask : fail

  task automatic chk_bit(logic g, logic e, string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask : chk_bit

  task automatic chk_vec(logic [7:0] g, logic [7:0] e, string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask : chk_vec

  task automatic chk_int(int g, int e, string m);
    n_checks++;
    if (g != e) fail(m);
  endtask : chk_int

  // Pulse counters let short one-cycle outputs be judged after the fact.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (wdt_clr === 1'b1) wdc <= wdc + 1;
    if (resume === 1'b1) res <= res + 1;
    if (sleep_act === 1'b1 || idle_act === 1'b1) act <= act + 1;
    if (cyc == 20000) begin
      fail("timeout");
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic wr_div(logic e, logic [2:0] r, logic i);
    @(posedge clk_sys);
    div_wr <= 1'b1; slow_en <= e; ratio <= r; return_on_interrupt <= i;
    @(posedge clk_sys);
    div_wr <= 1'b0;
    #1;
  endtask : wr_div

  task automatic wr_osc(logic [2:0] s, logic l);
    @(posedge clk_sys);
    osc_wr <= 1'b1; osc_sel <= s; osc_lock <= l;
    @(posedge clk_sys);
    osc_wr <= 1'b0;
    #1;
  endtask : wr_osc

  task automatic wr_gate(logic [7:0] v);
    logic [7:0] old;
    old = present & ~gate_exp;
    @(posedge clk_sys);
    gate_wr <= 1'b1; gate_in <= v;
    @(posedge clk_sys);
    gate_wr <= 1'b0;
    #1;
    gate_exp = v & present;
    chk_vec(pclk_en, old, "gate acted without delay");
    step(1);
    chk_vec(gate_q, gate_exp, "gate readback");
    step(1);
    chk_vec(pclk_en, present & ~gate_exp, "gate effect");
  endtask : wr_gate

  task automatic next_tick(output int n);
    n = 1;
    step(1);
    while (cpu_en !== 1'b1 && n < 300) begin
      step(1);
      n++;
    end
  endtask : next_tick

  // One power-save entry and wake; early raises the wake source together with the instruction.
  task automatic do_save(logic op, int src, logic w, logic c, logic v, logic early);
    int k, wdc0, act0, res0;
    @(posedge clk_sys);
    wdt_en <= w; cfm_en <= c; vreg <= v; ps_instr <= 1'b1; ps_op <= op;
    if (early) wake[src] <= 1'b1;
    wdc0 = wdc; act0 = act; res0 = res;
    @(posedge clk_sys);
    ps_instr <= 1'b0;
    #1;
    if (!early) begin
      k = 0;
      while ((op ? idle_act : sleep_act) !== 1'b1 && k < 8) begin
        step(1);
        k++;
      end
      chk_bit(op ? idle_act : sleep_act, 1'b1, "mode flag");
      chk_bit(cpu_en, 1'b0, "cpu clock in low power");
      if (op == PSM_OP_SLEEP) begin
        chk_bit(osc_en, 1'b0, "oscillator in sleep");
        chk_bit(cfm_act, 1'b0, "monitor in sleep");
        chk_bit(low_power_rc_osc_en, w, "rc osc in sleep");
        chk_bit(reg_stby, ~v, "regulator standby");
        chk_vec(pclk_en, present & ext_clk & ~gate_exp, "peripherals in sleep");
      end else begin
        chk_bit(osc_en, 1'b1, "oscillator in idle");
        chk_bit(low_power_rc_osc_en, w | c, "rc osc in idle");
        chk_bit(cfm_act, c, "monitor in idle");
        chk_vec(pclk_en, present & ~gate_exp & ~stop_in_idle, "peripherals in idle");
      end
      step(3);
      chk_bit(cpu_en, 1'b0, "cpu stays halted");
      chk_int(res, res0, "resumed without wake");
      @(posedge clk_sys);
      wake[src] <= 1'b1;
    end
    k = 0;
    do begin
      step(1);
      k++;
    end while (resume !== 1'b1 && k < 12);
    chk_bit(resume, 1'b1, "no resume");
    if (!early) chk_bit(k >= 3 && k <= 5, 1'b1, "resume delay");
    chk_int(wdc - wdc0, int'(w), "watchdog clear");
    chk_bit(act > act0, 1'b1, "entry not completed");
    @(posedge clk_sys);
    wake <= 3'h0;
    step(1);
    chk_bit(sleep_act | idle_act, 1'b0, "mode flag after wake");
    chk_bit(cpu_en, 1'b1, "cpu clock after wake");
    chk_bit(osc_en, 1'b1, "oscillator after wake");
    chk_vec({5'h00, osc_q}, 8'h05, "oscillator select after wake");
    chk_vec(pclk_en, present & ~gate_exp, "peripherals after wake");
  endtask : do_save

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    step(2);
    chk_bit(cpu_en, 1'b1, "reset cpu clock");
    chk_bit(osc_en, 1'b1, "reset oscillator");
    chk_bit(slow_q | roi_q, 1'b0, "reset slowdown bits");
    chk_vec({5'h00, ratio_q}, 8'h00, "reset ratio");
    chk_vec(gate_q, 8'h00, "reset gates");
    chk_vec(pclk_en, present, "reset peripheral clocks");
    $display("test reset done");

    wr_gate(8'h15);
    wr_gate(8'h00);
    wr_gate(8'h40);
    $display("test module gate done");

    wr_osc(3'h5, 1'b1);
    step(1);
    chk_vec({5'h00, osc_q}, 8'h00, "locked select written");
    wr_osc(3'h5, 1'b0);
    step(1);
    chk_vec({5'h00, osc_q}, 8'h05, "select not written");
    $display("test oscillator select done");

    do_save(PSM_OP_SLEEP, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    do_save(PSM_OP_SLEEP, 1, 1'b0, 1'b1, 1'b1, 1'b0);
    do_save(PSM_OP_SLEEP, 2, 1'b1, 1'b0, 1'b0, 1'b0);
    do_save(PSM_OP_IDLE, 0, 1'b0, 1'b1, 1'b0, 1'b0);
    do_save(PSM_OP_IDLE, 2, 1'b1, 1'b0, 1'b0, 1'b0);
    do_save(PSM_OP_IDLE, 1, 1'b0, 1'b0, 1'b0, 1'b0);
    do_save(PSM_OP_SLEEP, 0, 1'b1, 1'b0, 1'b0, 1'b1);
    do_save(PSM_OP_IDLE, 0, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test sleep and idle done");

    for (int r = 0; r < 8; r++) begin
      wr_div(1'b1, r[2:0], 1'b0);
      step(1);
      chk_bit(slow_q, 1'b1, "slowdown enable readback");
      chk_vec({5'h00, ratio_q}, r[7:0], "ratio readback");
      while (cpu_en !== 1'b1 && d < 300) begin
        step(1);
        d++;
      end
      next_tick(d);
      next_tick(d);
      chk_int(d, 1 << r, "cpu tick period");
      chk_bit(osc_en, 1'b1, "oscillator in slowdown");
      chk_vec(pclk_en, present & ~gate_exp, "peripherals in slowdown");
      d = 0;
    end
    $display("test slowdown ratios done");

    wr_div(1'b1, 3'h2, 1'b0);
    @(posedge clk_sys);
    wake[0] <= 1'b1;
    step(3);
    chk_bit(slow_q, 1'b1, "interrupt left slowdown");
    @(posedge clk_sys);
    wake[0] <= 1'b0;
    wr_div(1'b1, 3'h2, 1'b1);
    step(1);
    chk_bit(roi_q, 1'b1, "return bit readback");
    @(posedge clk_sys);
    wake[0] <= 1'b1;
    step(2);
    chk_bit(slow_q, 1'b0, "slowdown not cleared");
    for (int k = 0; k < 3; k++) begin
      step(1);
      chk_bit(cpu_en, 1'b1, "cpu not at full speed");
    end
    @(posedge clk_sys);
    wake[0] <= 1'b0;
    wr_div(1'b0, 3'h0, 1'b0);
    $display("test return on interrupt done");
    test_done();
  end
endmodule : tb_psm_power_manager

`default_nettype wire
